// ---- core/gpio_port_cfg.svh ----
// Register offsets, field positions and reset values for the eight-bit I/O port.
// Included by the port package users; holds definitions only.
`ifndef GPIO_PORT_CFG_SVH
`define GPIO_PORT_CFG_SVH
`define ADDR_PIN_DATA 8'h06
`define ADDR_OPTION 8'h81
`define ADDR_DIRECTION 8'h86
`define RST_OPTION 8'hFF
`define RST_DIRECTION 8'hFF
`define OPT_PULLUP_BIT 7
`define OPT_EDGE_BIT 6
`define EXT_IRQ_PIN 0
`define CHANGE_LO_PIN 4
`define PROG_CLK_PIN 6
`define PROG_DATA_PIN 7
`endif

// ---- core/gpio_port_pkg.sv ----
// Types shared by the eight-bit I/O port.
// Assumes nothing beyond the configuration header.
package gpio_port_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
    typedef struct packed {
        logic [7:0] pinOut;
        logic [7:0] pinOe;
        logic [7:0] pullupEn;
    } pin_drive_t;
endpackage

// ---- core/gpio_port_b.sv ----
// Eight-bit bidirectional I/O port with direction, weak pull-ups, pin 0 edge interrupt,
// change events on pins 4 to 7 and serial-programming taps on pins 6 and 7.
// Assumes a plain register port on mclk and pins that arrive from outside asynchronously.
//
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
`include "gpio_port_cfg.svh"
module gpio_port_b
    import gpio_port_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinOut,
    output logic [WIDTH-1:0] pinOe,
    output logic [WIDTH-1:0] pullupEn,
    input wire logic progMode,
    output logic progClock,
    output logic progDataIn,
    input wire logic progDataOut,
    input wire logic progDataOe,
    output logic extIrq,
    output logic changeIrq
);
    // =====================================================================
    // Register access
    // =====================================================================
    reg_req_t req;
    assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

    logic [7:0] dataLatch_q;
    logic [7:0] direction_q;
    logic [7:0] option_q;
    logic [7:0] regRdata_q;

    // Unmapped addresses decode to nothing: writes are dropped and reads return zero.
    wire selData = req.addr == `ADDR_PIN_DATA;
    wire selOpt = req.addr == `ADDR_OPTION;
    wire selDir = req.addr == `ADDR_DIRECTION;

    // The data latch has no reset at all so that it survives every reset.
    always_ff @(posedge mclk) begin
        if (req.wr && selData) begin
            dataLatch_q <= req.wdata;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            direction_q <= `RST_DIRECTION;
            option_q <= `RST_OPTION;
        end else if (req.wr) begin
            if (selDir) begin
                direction_q <= req.wdata;
            end
            if (selOpt) begin
                option_q <= req.wdata;
            end
        end
    end

    // =====================================================================
    // Pin input synchronisers
    // =====================================================================
    // Only the second stage reads the first one; the filter then waits for stages two and
    // three to agree, so a level caught mid-transition is never acted on.
    logic [WIDTH-1:0] sync1_q, sync2_q, sync3_q, pinLevel_q, pinLevel_d;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            pinLevel_q <= '0;
        end else begin
            sync1_q <= pinIn;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            pinLevel_q <= pinLevel_d;
        end
    end

    // A pin counts as changed only once the second and third stages agree.
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_filter
            assign pinLevel_d[g] = (sync2_q[g] == sync3_q[g]) ? sync3_q[g] : pinLevel_q[g];
        end
    endgenerate

    // Reading the data address returns pin levels, as the port is read at the pins.
    wire [7:0] rdMux = selData ? pinLevel_q[7:0] : selOpt ? option_q :
                       selDir ? direction_q : 8'h00;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata_q <= 8'h00;
        end else begin
            regRdata_q <= req.rd ? rdMux : 8'h00;
        end
    end
    assign regRdata = regRdata_q;

    // =====================================================================
    // Pin drive, pull-ups and programming taps
    // =====================================================================
    // Pin drive lags a register write by two cycles: one to land, one to register the drive.
    pin_drive_t drv_d, drv_q;
    wire pullOn = !option_q[`OPT_PULLUP_BIT];
    // In programming mode pin 6 is an input and pin 7 is steered by the programmer logic.
    wire [7:0] progOeMask = progMode ? 8'hC0 : 8'h00;
    always_comb begin
        drv_d.pinOut = dataLatch_q;
        drv_d.pinOe = ~direction_q & ~progOeMask;
        drv_d.pinOut[`PROG_DATA_PIN] = progMode ? progDataOut : dataLatch_q[`PROG_DATA_PIN];
        drv_d.pinOe[`PROG_DATA_PIN] = progMode ? progDataOe : !direction_q[`PROG_DATA_PIN];
        drv_d.pullupEn = pullOn ? direction_q : 8'h00;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            drv_q <= '{pinOut: 8'h00, pinOe: 8'h00, pullupEn: 8'h00};
            progClock <= 1'h0;
            progDataIn <= 1'h0;
        end else begin
            drv_q <= drv_d;
            progClock <= progMode & pinLevel_q[`PROG_CLK_PIN];
            progDataIn <= progMode & pinLevel_q[`PROG_DATA_PIN];
        end
    end
    assign pinOut = drv_q.pinOut;
    assign pinOe = drv_q.pinOe;
    assign pullupEn = drv_q.pullupEn;

    // =====================================================================
    // Events
    // =====================================================================
    logic [WIDTH-1:0] prevLevel_q;
    logic [4:0] settle_q;
    logic extIrq_q, changeIrq_q;
    wire edgeRise = option_q[`OPT_EDGE_BIT];
    wire p0Now = pinLevel_q[`EXT_IRQ_PIN];
    wire p0Was = prevLevel_q[`EXT_IRQ_PIN];
    wire extHit = edgeRise ? (p0Now && !p0Was) : (!p0Now && p0Was);
    wire changeHit = |(pinLevel_q[7:`CHANGE_LO_PIN] ^ prevLevel_q[7:`CHANGE_LO_PIN]);
    // The filter and the edge history restart from zero, which is not the idle level of a
    // pulled-up pin. Events stay masked until both hold real pin levels again, so a reset
    // never turns into a false edge; the price is five quiet cycles after every reset.
    wire eventsArmed = settle_q[4];

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prevLevel_q <= '0;
            settle_q <= 5'h00;
            extIrq_q <= 1'h0;
            changeIrq_q <= 1'h0;
        end else begin
            prevLevel_q <= pinLevel_q;
            settle_q <= {settle_q[3:0], 1'h1};
            extIrq_q <= extHit & eventsArmed;
            changeIrq_q <= changeHit & eventsArmed;
        end
    end
    assign extIrq = extIrq_q;
    assign changeIrq = changeIrq_q;

    // =====================================================================
    // Checks
    // =====================================================================
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_dir_reset: assert property (!$past(rst_n) |-> direction_q == 8'hFF)
        else $error("Direction not all ones after reset.");
    chk_opt_reset: assert property (!$past(rst_n) |-> option_q == 8'hFF)
        else $error("Option not all ones after reset.");
    chk_data_write: assert property (req.wr && selData |=> dataLatch_q == $past(req.wdata))
        else $error("Data latch missed a write.");
    chk_output_drive: assert property (!progMode && !direction_q[1] |=> pinOe[1])
        else $error("Output pin not driven.");
    // Hit checks judge armed cycles only; the quiet and wrong-edge checks run in every cycle, and the masked start-up window is checked apart.
    wire pin5Moved = pinLevel_q[5] != prevLevel_q[5];
    chk_events_masked: assert property (!eventsArmed |=> !extIrq && !changeIrq)
        else $error("Event raised before the filter settled.");
    chk_change_event: assert property (eventsArmed && pin5Moved |=> changeIrq)
        else $error("Change on pin 5 not flagged.");
    chk_change_quiet: assert property (pinLevel_q[7:4] == prevLevel_q[7:4] |=> !changeIrq)
        else $error("Change event without a change.");
    chk_oe_input: assert property (!progMode && direction_q[3] |=> !pinOe[3])
        else $error("Input pin driven.");
    chk_pullup_input: assert property (pullupEn[2] |-> $past(direction_q[2]) && $past(pullOn))
        else $error("Pull-up on a non-input pin.");
    chk_pullup_off: assert property (option_q[7] |=> pullupEn == 8'h00)
        else $error("Pull-ups on while disabled.");
    chk_prog_clock: assert property (progMode && pinLevel_q[6] |=> progClock)
        else $error("Programming clock not passed.");
    chk_prog_data: assert property (progMode && pinLevel_q[7] |=> progDataIn)
        else $error("Programming data not passed.");
    chk_edge_rise: assert property (eventsArmed && edgeRise && p0Now && !p0Was |=> extIrq)
        else $error("Rising edge missed.");
    chk_fall_hit: assert property (eventsArmed && !edgeRise && !p0Now && p0Was |=> extIrq)
        else $error("Falling edge missed.");
    chk_edge_fall: assert property (!edgeRise && p0Now && !p0Was |=> !extIrq)
        else $error("Wrong edge fired.");

    // Covers mark that each event path and the pull-up path were exercised at all.
    cov_ext_irq: cover property (extIrq);
    cov_pullup: cover property (|pullupEn);
    cov_change_irq: cover property (changeIrq);
    cov_prog: cover property (progMode && progClock);
endmodule

// ---- testbench/pin_model.sv ----
// Board around the port: outside drivers, weak pull-ups and the level each pin settles to.
// Assumes the bench sets the outside drive; the port's own drive wins any contention.
`timescale 1ns/10ps
module pin_model (
    input wire logic [7:0] pinOut,
    input wire logic [7:0] pinOe,
    input wire logic [7:0] pullupEn,
    input wire logic [7:0] extVal,
    input wire logic [7:0] extOe,
    output logic [7:0] pinIn
);
    logic noise = 1'h0;
    // A floating pin wanders rather than quietly holding its last level.
    always #12 noise = ~noise;
    assign pinIn = (pinOe & pinOut) | (~pinOe & extOe & extVal)
        | (~pinOe & ~extOe & (pullupEn | {8{noise}}));
endmodule

// ---- testbench/eight_bit_io_port_b_tb.sv ----
// Self-checking bench for the eight-bit port: registers, pins, events, programming taps.
// Assumes the port package, its header and the pin model are compiled alongside.
`timescale 1ns/10ps
`include "gpio_port_cfg.svh"
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin n_fail++; \
    $display("[ERR] %s exp %h got %h", nm, exp, got); end end
module eight_bit_io_port_b_tb;
    import gpio_port_pkg::*;
    logic mclk = 1'h0, rst_n = 1'h0, regWr = 1'h0, regRd = 1'h0;
    logic progMode = 1'h0, progDataOut = 1'h0, progDataOe = 1'h0;
    logic [7:0] regAddr = 8'h00, regWdata = 8'h00, extVal = 8'h00, extOe = 8'hFF;
    logic [7:0] regRdata, rdv, pinIn, pinOut, pinOe, pullupEn;
    logic progClock, progDataIn, extIrq, changeIrq;
    int n_fail = 0, comparisons = 0, nExt = 0, nChg = 0, n0;
    always #4 mclk = ~mclk;
    always @(posedge mclk) begin
        nExt <= nExt + extIrq;
        nChg <= nChg + changeIrq;
    end
    gpio_port_b dut (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .pinIn(pinIn), .pinOut(pinOut),
        .pinOe(pinOe), .pullupEn(pullupEn), .progMode(progMode), .progClock(progClock),
        .progDataIn(progDataIn), .progDataOut(progDataOut), .progDataOe(progDataOe),
        .extIrq(extIrq), .changeIrq(changeIrq));
    pin_model board (.pinOut(pinOut), .pinOe(pinOe), .pullupEn(pullupEn), .extVal(extVal),
        .extOe(extOe), .pinIn(pinIn));
    // ==========================================================
    // Bus cycles
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk) begin
            regAddr <= a;
            regWdata <= d;
            regWr <= 1'h1;
        end
        @(posedge mclk) regWr <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk) begin
            regAddr <= a;
            regRd <= 1'h1;
        end
        @(posedge mclk) regRd <= 1'h0;
        #1 rdv = regRdata;
    endtask
    // Pin paths pass five flops, so eight cycles covers every settle.
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_drive;
        rd(`ADDR_DIRECTION);
        `CHK("dir", 8'hFF, rdv)
        wr(8'h01, 8'h00);
        rd(`ADDR_OPTION);
        `CHK("opt", 8'hFF, rdv)
        rd(8'h01);
        `CHK("unmapped", 8'h00, rdv)
        `CHK("pullupRst", 8'h00, pullupEn)
        extOe <= 8'h0F;
        extVal <= 8'h03;
        wr(`ADDR_PIN_DATA, 8'hA5);
        wr(`ADDR_DIRECTION, 8'h0F);
        idle(8);
        `CHK("oe", 8'hF0, pinOe)
        `CHK("out", 8'hA0, pinOut & 8'hF0)
        rd(`ADDR_PIN_DATA);
        `CHK("pins", 8'hA3, rdv)
        wr(`ADDR_OPTION, 8'h7F);
        idle(3);
        `CHK("pullIn", 8'h0F, pullupEn)
        extOe <= 8'hFF;
        wr(`ADDR_DIRECTION, 8'hFF);
        idle(3);
        `CHK("pullAll", 8'hFF, pullupEn)
    endtask
    task automatic t_events;
        for (int e = 0; e < 2; e++) begin
            wr(`ADDR_OPTION, e ? 8'h7F : 8'h3F);
            extVal <= {7'h00, e[0]};
            idle(8);
            n0 = nExt;
            extVal <= {7'h00, ~e[0]};
            idle(8);
            extVal <= {7'h00, e[0]};
            idle(8);
            `CHK("extIrq", 1, nExt - n0)
        end
        for (int p = 0; p < 8; p++) begin
            n0 = nChg;
            extVal <= extVal ^ (8'h01 << p);
            idle(8);
            `CHK("chgIrq", int'(p >= 4), nChg - n0)
        end
    endtask
    task automatic t_prog;
        @(posedge mclk);
        progMode <= 1'h1;
        extVal <= 8'h40;
        idle(8);
        `CHK("progClk", 1'h1, progClock)
        `CHK("progDin", 1'h0, progDataIn)
        extVal <= 8'h80;
        idle(8);
        `CHK("progClk0", 1'h0, progClock)
        `CHK("progDin1", 1'h1, progDataIn)
        @(posedge mclk);
        extOe <= 8'h7F;
        progDataOut <= 1'h1;
        progDataOe <= 1'h1;
        idle(4);
        `CHK("progOe", 1'h1, pinOe[7])
        `CHK("progOut", 1'h1, pinOut[7])
        @(posedge mclk);
        progMode <= 1'h0;
        progDataOe <= 1'h0;
        extOe <= 8'hFF;
    endtask
    task automatic t_keep;
        wr(`ADDR_PIN_DATA, 8'h5A);
        rst_n <= 1'h0;
        idle(3);
        @(posedge mclk);
        rst_n <= 1'h1;
        idle(1);
        rd(`ADDR_DIRECTION);
        `CHK("dirRst", 8'hFF, rdv)
        extOe <= 8'h00;
        wr(`ADDR_DIRECTION, 8'h00);
        idle(3);
        `CHK("latch", 8'h5A, pinOut)
    endtask
    task automatic end_sim;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'h1;
        t_drive;
        t_events;
        t_prog;
        t_keep;
        end_sim;
    end
    initial begin
        #100000;
        n_fail++;
        end_sim;
    end
endmodule
